/* pkg/abo_pkg.sv */
package abo_pkg;

    // ----------------------------------------------------------------
    // Register map, indices: byte address is four times the index.
    // ----------------------------------------------------------------
    localparam int ABO_AW = 12;
    localparam int ABO_DW = 32;
    localparam logic [5:0] IDX_CFG0 = 6'h01;
    localparam logic [5:0] IDX_OVR = 6'h02;
    localparam logic [5:0] IDX_DCA = 6'h03;
    localparam logic [5:0] IDX_STAT = 6'h04;
    localparam logic [5:0] IDX_DCB = 6'h1A;

    // ----------------------------------------------------------------
    // Field positions and reset values.
    // ----------------------------------------------------------------
    localparam int CFG_W = 6;
    localparam logic [5:0] CFG0_RST = 6'h00;
    localparam int DC_EN_BIT = 0;
    localparam int THR_LSB = 0;
    localparam int THR_W = 4;
    localparam logic [3:0] THR_RST = 4'hF;
    localparam int NLEN_LSB = 8;
    localparam int NLEN_W = 5;
    localparam logic [4:0] N_RST = 5'h0A;
    localparam logic [4:0] N_MIN = 5'h0A;
    localparam logic [4:0] N_MAX = 5'h19;
    localparam int ST_READY_BIT = 0;
    localparam int ST_HIRES_BIT = 1;
    localparam int ST_OVR_LSB = 2;
    localparam int ST_STATE_LSB = 4;

    // ----------------------------------------------------------------
    // Data path and sequencer constants.
    // ----------------------------------------------------------------
    localparam int SMP_W = 12;
    localparam int NCH = 2;
    localparam int OVR_LAT = 12;
    localparam int FS_SHIFT = 7;
    localparam int DC_SHIFT = 6;
    localparam logic [11:0] LR9_MASK = 12'hFF8;
    localparam logic [11:0] LR11_MASK = 12'hFFE;
    localparam logic [1:0] DECIM_PH0 = 2'h0;
    localparam int CNT_W = 28;
    localparam logic [4:0] FIRST_EXP = 5'h0D;
    localparam logic [4:0] LOW_EXP_ADD = 5'h03;

    typedef enum logic [2:0] {
        ABO_IDLE = 3'b000,
        ABO_LOW = 3'b001,
        ABO_READY = 3'b011,
        ABO_ARMED = 3'b010,
        ABO_HIGH = 3'b110
    } abo_state_t;

    typedef struct packed {
        logic [1:0] hp;
        logic decim;
        logic auto_trig;
        logic burst_en;
        logic ilv_en;
    } abo_cfg_t;

endpackage : abo_pkg

/* hw/abo_delay.sv */
`timescale 1ns/1ps

module abo_delay
    import abo_pkg::*;
#(
    parameter int W = NCH,
    parameter int D = OVR_LAT - 1
) (
    // Clock, reset and clock enable.
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    // Data.
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] stage [D];

    // ----------------------------------------------------------------
    // Shift line, read data leave the last register.
    // ----------------------------------------------------------------
    genvar i;
    for (i = 0; i < D; i++) begin : g_stage
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                stage[i] <= '0;
            end else if (ce) begin
                stage[i] <= (i == 0) ? din : stage[(i == 0) ? 0 : i - 1];
            end
        end
    end

    assign dout = stage[D-1];

endmodule : abo_delay

/* hw/abo_ctrl.sv */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// - Over-range flag appears twelve cycles after sample.
// - Trip level is full scale times threshold/16.
// - Threshold resets to fifteen.
// - Interleave auto-correction bit, off after reset.
// - DC correction enabled per channel separately.
// - Per-channel filter selectable low-pass or high-pass.
// - Burst alternates 2^N full and 2^(N+3) reduced samples.
// - Manual trigger mode or automatic mode.
// - First block is 2^13 low samples, trigger ignored.
// - New N applies from next low block.
// - N resets to 10, range 10 to 25.
// - Manual mode raises ready after low block.
// - Trigger sampled each clock, rising edge requests.
// - Full resolution starts 1-2 output clocks later.
// - After high block reread N, start low block.
// - Ready rises again after last low sample.
// - Triggers during lockout are discarded.
// - Auto mode: 2^13 low, then high without trigger.
// - Auto mode ignores trigger, ready pulses once.
// - After high block, low output and lockout.
// - Full-rate low option keeps nine MSBs.
// - Decimated option keeps eleven MSBs, repeats four.
module abo_ctrl
    import abo_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    // APB slave.
    input wire logic [ABO_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ABO_DW-1:0] pwdata,
    output logic [ABO_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter samples.
    input wire logic [SMP_W-1:0] chan_a_sample,
    input wire logic [SMP_W-1:0] chan_b_sample,
    // Link pins.
    input wire logic burst_trigger_pair,
    input wire logic output_data_clock,
    // Output data and flags.
    output logic [SMP_W-1:0] chan_a_data_out,
    output logic [SMP_W-1:0] chan_b_data_out,
    output logic [NCH-1:0] over_range_flag,
    output logic trigger_ready_flag,
    output logic high_res_flag
);

    localparam int MAX_ARM = 24;

    abo_cfg_t cfg;
    logic [THR_W-1:0] thresh;
    logic [NLEN_W-1:0] n_reg;
    logic [NCH-1:0] dc_en;
    abo_state_t state;
    abo_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [NLEN_W-1:0] lo_exp;
    logic [NLEN_W-1:0] n_cur;
    logic [CNT_W-1:0] lo_last;
    logic [CNT_W-1:0] hi_last;
    logic trig_meta, trig_sync, trig_prev;
    logic oclk_meta, oclk_sync, oclk_prev;
    logic trig_edge, oclk_rise;
    logic [1:0] phase;
    logic in_low;
    logic [NCH-1:0] trip;
    logic [NCH-1:0] trip_dly;
    logic [SMP_W-1:0] smp [NCH];
    logic [SMP_W-1:0] dout [NCH];
    logic [5:0] idx;
    logic mapped, setup, wr_en;
    logic [NLEN_W-1:0] n_wr;
    logic [ABO_DW-1:0] rd_word;

    // ----------------------------------------------------------------
    // APB slave.
    // ----------------------------------------------------------------
    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && mapped;
    assign mapped = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0)
        && (idx == IDX_CFG0 || idx == IDX_OVR || idx == IDX_DCA
        || idx == IDX_STAT || idx == IDX_DCB);
    assign n_wr = pwdata[NLEN_LSB +: NLEN_W];

    always_comb begin
        rd_word = '0;
        unique case (idx)
            IDX_CFG0: rd_word[CFG_W-1:0] = cfg;
            IDX_OVR: begin
                rd_word[THR_LSB +: THR_W] = thresh;
                rd_word[NLEN_LSB +: NLEN_W] = n_reg;
            end
            IDX_DCA: rd_word[DC_EN_BIT] = dc_en[0];
            IDX_DCB: rd_word[DC_EN_BIT] = dc_en[1];
            IDX_STAT: begin
                rd_word[ST_READY_BIT] = trigger_ready_flag;
                rd_word[ST_HIRES_BIT] = high_res_flag;
                rd_word[ST_OVR_LSB +: NCH] = over_range_flag;
                rd_word[ST_STATE_LSB +: 3] = state;
            end
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && mapped) ? rd_word : '0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            thresh <= THR_RST;
            n_reg <= N_RST;
            cfg <= abo_cfg_t'(CFG0_RST);
            dc_en <= '0;
        end else if (ce && wr_en) begin
            if (idx == IDX_CFG0) begin
                cfg <= abo_cfg_t'(pwdata[CFG_W-1:0]);
            end
            if (idx == IDX_OVR) begin
                thresh <= pwdata[THR_LSB +: THR_W];
                n_reg <= (n_wr < N_MIN) ? N_MIN
                    : ((n_wr > N_MAX) ? N_MAX : n_wr);
            end
            if (idx == IDX_DCA) begin
                dc_en[0] <= pwdata[DC_EN_BIT];
            end
            if (idx == IDX_DCB) begin
                dc_en[1] <= pwdata[DC_EN_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection.
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
            oclk_meta <= 1'b0;
            oclk_sync <= 1'b0;
            oclk_prev <= 1'b0;
        end else if (ce) begin
            trig_meta <= burst_trigger_pair;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
            oclk_meta <= output_data_clock;
            oclk_sync <= oclk_meta;
            oclk_prev <= oclk_sync;
        end
    end

    assign trig_edge = trig_sync && !trig_prev;
    assign oclk_rise = oclk_sync && !oclk_prev;

    // ----------------------------------------------------------------
    // Burst sequencer.
    // ----------------------------------------------------------------
    // wide sample counter
    assign lo_last = (CNT_W'(1) << lo_exp) - CNT_W'(1);
    assign hi_last = (CNT_W'(1) << n_cur) - CNT_W'(1);
    assign in_low = (next_state == ABO_LOW) || (next_state == ABO_READY)
        || (next_state == ABO_ARMED);

    always_comb begin
        next_state = state;
        unique case (state)
            ABO_IDLE: begin
                if (cfg.burst_en) begin
                    next_state = ABO_LOW;
                end
            end
            ABO_LOW: begin
                if (cnt == lo_last) begin
                    next_state = cfg.auto_trig ? ABO_HIGH : ABO_READY;
                end
            end
            ABO_READY: begin
                if (cfg.auto_trig) begin
                    next_state = ABO_HIGH;
                end else if (trig_edge) begin
                    next_state = ABO_ARMED;
                end
            end
            ABO_ARMED: begin
                if (oclk_rise) begin
                    next_state = ABO_HIGH;
                end
            end
            ABO_HIGH: begin
                if (cnt == hi_last) begin
                    next_state = ABO_LOW;
                end
            end
            default: next_state = ABO_IDLE;
        endcase
        if (!cfg.burst_en) begin
            next_state = ABO_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ABO_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
            lo_exp <= FIRST_EXP;
            n_cur <= N_RST;
        end else if (ce) begin
            if (state != next_state) begin
                cnt <= '0;
            end else if (state == ABO_LOW || state == ABO_HIGH) begin
                cnt <= cnt + CNT_W'(1);
            end
            if (state == ABO_IDLE && next_state == ABO_LOW) begin
                lo_exp <= FIRST_EXP;
                n_cur <= n_reg;
            end else if (state == ABO_HIGH && next_state == ABO_LOW) begin
                lo_exp <= n_reg + LOW_EXP_ADD;
                n_cur <= n_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trigger_ready_flag <= 1'b0;
            high_res_flag <= 1'b0;
        end else if (ce) begin
            high_res_flag <= (next_state == ABO_HIGH);
            if (cfg.auto_trig) begin
                trigger_ready_flag <= (next_state == ABO_HIGH)
                    && (state != ABO_HIGH);
            end else begin
                trigger_ready_flag <= (next_state == ABO_READY);
            end
        end
    end

    // ----------------------------------------------------------------
    // Per-channel data path and over-range detect.
    // ----------------------------------------------------------------
    assign smp[0] = chan_a_sample;
    assign smp[1] = chan_b_sample;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= DECIM_PH0;
        end else if (ce) begin
            phase <= phase + 2'h1;
        end
    end

    genvar ch;
    for (ch = 0; ch < NCH; ch++) begin : g_chan
        logic [SMP_W-1:0] prev;
        logic [SMP_W-1:0] est;
        logic [SMP_W-1:0] hold;
        logic [SMP_W:0] sum;
        logic [SMP_W-1:0] filt;
        logic [SMP_W-1:0] corr;
        logic [SMP_W-1:0] diff;
        logic [SMP_W-1:0] mag;

        assign mag = smp[ch][SMP_W-1] ? SMP_W'(-smp[ch]) : smp[ch];
        assign trip[ch] = mag > SMP_W'({thresh, FS_SHIFT'(0)});

        assign sum = cfg.hp[ch]
            ? ({smp[ch][SMP_W-1], smp[ch]} - {prev[SMP_W-1], prev})
            : ({smp[ch][SMP_W-1], smp[ch]} + {prev[SMP_W-1], prev});
        assign filt = sum[SMP_W:1];
        assign diff = filt - est;
        assign corr = dc_en[ch] ? (filt - est) : filt;

        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                prev <= '0;
                est <= '0;
                hold <= '0;
                dout[ch] <= '0;
            end else if (ce) begin
                prev <= smp[ch];
                if (cfg.ilv_en) begin
                    est <= est + SMP_W'($signed(diff) >>> DC_SHIFT);
                end
                if (phase == DECIM_PH0) begin
                    hold <= corr & LR11_MASK;
                end
                if (!in_low) begin
                    dout[ch] <= corr;
                end else if (cfg.decim) begin
                    dout[ch] <= (phase == DECIM_PH0)
                        ? (corr & LR11_MASK) : hold;
                end else begin
                    dout[ch] <= corr & LR9_MASK;
                end
            end
        end
    end

    assign chan_a_data_out = dout[0];
    assign chan_b_data_out = dout[1];

    abo_delay #(.W(NCH), .D(OVR_LAT - 1)) u_ovr_dly (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .din(trip),
        .dout(trip_dly)
    );

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            over_range_flag <= '0;
        end else if (ce) begin
            over_range_flag <= trip_dly;
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    logic [3:0] ce_run;
    logic [CNT_W:0] hr_len;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ce_run <= '0;
            hr_len <= '0;
        end else begin
            ce_run <= !ce ? 4'h0 : ((ce_run == 4'hF) ? ce_run
                : ce_run + 4'h1);
            if (ce) begin
                hr_len <= high_res_flag ? hr_len + (CNT_W+1)'(1) : '0;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_armed;
        state == ABO_ARMED && ce;
    endsequence

    sequence s_high_start;
        state == ABO_HIGH && high_res_flag;
    endsequence

    ovr_latency_a: assert property (
        ce_run >= 4'd13 && $past(trip[0], 12) |-> over_range_flag[0])
        else $error("over-range flag missed its latency");
    thr_reset_a: assert property (
        @(posedge sys_clk) $rose(resetn) |-> thresh == THR_RST)
        else $error("threshold not at reset value");
    ilv_reset_a: assert property (
        @(posedge sys_clk) $rose(resetn) |-> !cfg.ilv_en)
        else $error("auto-correction enabled at reset");
    n_range_a: assert property (
        n_reg >= N_MIN && n_reg <= N_MAX && n_cur >= N_MIN)
        else $error("burst length out of range");
    first_block_a: assert property (
        state == ABO_IDLE && next_state == ABO_LOW && ce
        |=> lo_exp == FIRST_EXP && cnt == '0)
        else $error("first low block length wrong");
    lock_trig_a: assert property (
        state == ABO_LOW && cnt != lo_last && trig_edge
        |=> state != ABO_ARMED && state != ABO_HIGH)
        else $error("trigger accepted during lockout");
    arm_delay_a: assert property (
        s_armed ##0 ce_run == 4'hF |-> ##[1:MAX_ARM] s_high_start)
        else $error("high resolution did not start in time");
    hires_len_a: assert property (
        ce && $fell(high_res_flag) && state == ABO_LOW
        |-> $past(hr_len) == (CNT_W+1)'($past(hi_last)))
        else $error("high resolution block length wrong");
    auto_pulse_a: assert property (
        cfg.auto_trig && $past(cfg.auto_trig) && trigger_ready_flag && ce
        |=> !trigger_ready_flag)
        else $error("ready pulse longer than one cycle");
    ready_low_a: assert property (
        !cfg.auto_trig && cfg.burst_en && state == ABO_LOW
        && cnt == lo_last && ce |=> trigger_ready_flag)
        else $error("ready not raised after low block");

endmodule : abo_ctrl

/* sim/abo_rx_model.sv */
`timescale 1ns/1ps

module abo_rx_model (
    // Command from the bench.
    input wire logic trig_cmd,
    // Link pins.
    output logic burst_trigger_pair,
    output logic output_data_clock
);
    // ------
    // Output clock and trigger launch.
    // ------
    initial begin
        output_data_clock = 1'b0;
        burst_trigger_pair = 1'b0;
        #37;
        forever #100 output_data_clock = ~output_data_clock;
    end

    always @(posedge output_data_clock) begin
        burst_trigger_pair <= trig_cmd;
    end
endmodule : abo_rx_model

/* sim/adc_burst_output_overrange_ctrl_tb.sv */
`timescale 1ns/1ps

module adc_burst_output_overrange_ctrl_tb;
    import abo_pkg::*;
    typedef struct packed {logic wr; logic err; logic [31:0] d;} abo_note_t;
    typedef struct packed {int c; logic [1:0] v;} abo_ovr_t;
    logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic trig_cmd, rnd_on, trigger_ready_flag, high_res_flag, ce;
    logic burst_trigger_pair, output_data_clock;
    logic [11:0] paddr, inj_a, inj_b, chan_a_sample, chan_b_sample;
    logic [11:0] chan_a_data_out, chan_b_data_out, prev;
    logic [31:0] pwdata, prdata;
    logic [1:0] over_range_flag;
    int error_cnt, check_count, cyc, rdy_cnt, n, r0, ch;
    bit seeded;
    abo_note_t apb_q[$];
    abo_note_t nt;
    abo_ovr_t ovr_q[$];
    abo_ovr_t on;
    logic [11:0] ra[5] = '{12'h004, 12'h008, 12'h00C, 12'h068, 12'h014};
    logic [31:0] rv[5] = '{0, 32'h0A0F, 0, 0, 0};
    logic [11:0] wa[8] = '{12'h004, 12'h00C, 12'h068, 12'h008, 12'h008,
        12'h004, 12'h00C, 12'h068};
    logic [31:0] wd[8] = '{1, 1, 1, 32'h1F0F, 32'h0508, 0, 0, 0};
    logic [31:0] wv[8] = '{1, 1, 1, 32'h190F, 32'h0A08, 0, 0, 0};
    logic [31:0] fc[3] = '{32'h10, 32'h20, 32'h00};
    logic [11:0] fa[3] = '{12'h000, 12'h123, 12'h123};
    logic [11:0] fb[3] = '{12'h123, 12'h000, 12'h123};
    logic [11:0] oa[4] = '{12'h401, 12'h123, 12'h400, 12'h7FF};
    logic [11:0] ob[4] = '{12'h123, 12'hBFF, 12'hC00, 12'h800};
    logic [1:0] ov[4] = '{2'b01, 2'b10, 2'b00, 2'b11};

    abo_ctrl dut (.sys_clk, .resetn, .ce, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .chan_a_sample,
        .chan_b_sample, .burst_trigger_pair, .output_data_clock,
        .chan_a_data_out, .chan_b_data_out, .over_range_flag,
        .trigger_ready_flag, .high_res_flag);
    abo_rx_model rx (.trig_cmd, .burst_trigger_pair, .output_data_clock);

    always #12.5 sys_clk = ~sys_clk;

    // ------
    // Shared tasks.
    // ------
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] e, input logic er);
        apb_q.push_back('{w, er, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic run_len(input bit k, input logic lvl, output int c);
        c = 0;
        while ((k ? high_res_flag : trigger_ready_flag) === lvl && c < 70000)
        begin
            @(posedge sys_clk);
            c++;
        end
    endtask : run_len

    task automatic ticks(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : ticks

    // ------
    // Samples and result watcher.
    // ------
    always @(posedge sys_clk) begin
        if (!seeded) begin
            void'($urandom(25));
            seeded = 1'b1;
        end
        chan_a_sample <= rnd_on ? 12'($urandom % 2001 - 1000) : inj_a;
        chan_b_sample <= rnd_on ? 12'($urandom % 2001 - 1000) : inj_b;
        cyc <= cyc + 1;
        if (trigger_ready_flag === 1'b1)
            rdy_cnt <= rdy_cnt + 1;
        if (psel && penable && pready === 1'b1 && apb_q.size() > 0) begin
            nt = apb_q.pop_front();
            chk("pslverr", nt.err, pslverr);
            if (!nt.wr)
                chk("prdata", nt.d, prdata);
        end
        if (resetn && over_range_flag !== 2'b00) begin
            on = (ovr_q.size() > 0) ? ovr_q.pop_front()
                : abo_ovr_t'{0, 2'b00};
            chk("ovr cycle", on.c, cyc);
            chk("ovr flag", on.v, over_range_flag);
        end
        if (cyc > 60000) begin
            $display("[FAIL] timeout expected %0d seen %0d", 60000, cyc);
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        {sys_clk, resetn, psel, penable, pwrite, trig_cmd} = '0;
        ce = 1'b1;
        {paddr, pwdata, inj_a, inj_b, chan_a_sample, chan_b_sample} = '0;
        {error_cnt, check_count, cyc, rdy_cnt} = '0;
        rnd_on = 1'b1;
        ticks(4);
        resetn <= 1'b1;
        @(posedge sys_clk);
        foreach (ra[i]) apb(0, ra[i], 0, rv[i], i == 4);
        foreach (wa[i]) begin
            apb(1, wa[i], wd[i], 0, 0);
            apb(0, wa[i], 0, wv[i], 0);
        end
        $display("test registers done");
        rnd_on <= 1'b0;
        inj_a <= 12'h123;
        inj_b <= 12'h123;
        foreach (fc[i]) begin
            apb(1, 12'h004, fc[i], 0, 0);
            ticks(4);
            chk("data a", fa[i], chan_a_data_out);
            chk("data b", fb[i], chan_b_data_out);
        end
        foreach (ov[i]) begin
            inj_a <= oa[i];
            inj_b <= ob[i];
            if (ov[i] != 2'b00)
                ovr_q.push_back('{cyc + 14, ov[i]});
            @(posedge sys_clk);
            inj_a <= 12'h123;
            inj_b <= 12'h123;
            ticks(20);
        end
        chk("ovr pending", 0, ovr_q.size());
        $display("test filter and over-range done");
        rnd_on <= 1'b1;
        ce <= 1'b0;
        ticks(2);
        prev = chan_a_data_out;
        ticks(10);
        chk("ce freeze", prev, chan_a_data_out);
        ce <= 1'b1;
        $display("test clock enable done");
        apb(1, 12'h004, 32'h02, 0, 0);
        trig_cmd <= 1'b1;
        ticks(2000);
        chk("low 9 bit", 0, chan_a_data_out[2:0]);
        trig_cmd <= 1'b0;
        run_len(0, 0, n);
        chk("first low", 1, n > 6187 && n < 6197);
        ticks(100);
        chk("ready hold", 2'b10, {trigger_ready_flag, high_res_flag});
        apb(0, 12'h010, 0, 32'h31, 0);
        apb(1, 12'h008, 32'h0B08, 0, 0);
        trig_cmd <= 1'b1;
        run_len(1, 0, n);
        chk("trig delay", 1, n <= 30);
        run_len(1, 1, n);
        chk("high len", 1024, n);
        trig_cmd <= 1'b0;
        ticks(50);
        trig_cmd <= 1'b1;
        ticks(20);
        run_len(0, 0, n);
        chk("low len", 1, n > 16312 && n < 16317);
        ticks(100);
        chk("no stored", 0, high_res_flag);
        trig_cmd <= 1'b0;
        ticks(20);
        trig_cmd <= 1'b1;
        run_len(1, 0, n);
        run_len(1, 1, n);
        chk("high len n11", 2048, n);
        $display("test manual burst done");
        apb(1, 12'h004, 0, 0, 0);
        apb(1, 12'h008, 32'h0A08, 0, 0);
        apb(1, 12'h004, 32'h0E, 0, 0);
        repeat (40) begin
            trig_cmd <= ~trig_cmd;
            ticks(25);
        end
        ch = 0;
        prev = chan_b_data_out;
        repeat (8) begin
            @(posedge sys_clk);
            ch += (chan_b_data_out !== prev);
            prev = chan_b_data_out;
            chk("dec lsb", 0, chan_b_data_out[0]);
        end
        chk("dec repeat", 1, ch <= 2);
        r0 = rdy_cnt;
        run_len(0, 0, n);
        chk("auto low", 1, n > 7179 && n < 7193);
        chk("auto start", 1, high_res_flag);
        run_len(1, 1, n);
        chk("auto high", 1024, n);
        chk("ready pulse", r0 + 1, rdy_cnt);
        $display("test auto burst done");
        end_of_test();
    end
endmodule : adc_burst_output_overrange_ctrl_tb
